// ### pkg/ckoe_pkg.sv
// package: register map, fields and reset values of the clock output control
package ckoe_pkg;
    localparam int NUM_OUT = 7;   // output drivers
    localparam int NUM_LOOP = 4;  // synthesis loops
    localparam int SYNC_W = 6;    // pin, alarm and four unlock inputs
    // global register byte addresses
    localparam logic [15:0] ADDR_KILL = 16'h0102;
    localparam logic [15:0] ADDR_LOS_MASK = 16'h0141;
    localparam logic [15:0] ADDR_UNLOCK_MASK = 16'h0142;
    localparam logic [15:0] ADDR_MODE = 16'h0144;
    localparam logic [15:0] ADDR_INT_STAT = 16'h0150;
    localparam logic [15:0] ADDR_INT_MASK = 16'h0151;
    localparam logic [15:0] ADDR_EN_STAT = 16'h0152;
    // per-output byte addresses, output 0 first
    localparam logic [15:0] ADDR_OE [NUM_OUT] = '{16'h0112, 16'h0117, 16'h011C,
        16'h0126, 16'h012B, 16'h0130, 16'h013A};
    localparam logic [15:0] ADDR_CFG [NUM_OUT] = '{16'h0113, 16'h0118, 16'h011D,
        16'h0127, 16'h012C, 16'h0131, 16'h013B};
    localparam logic [15:0] ADDR_POL [NUM_OUT] = '{16'h0115, 16'h011A, 16'h011F,
        16'h0129, 16'h012E, 16'h0133, 16'h013D};
    // field positions
    localparam int KILL_BIT = 0;
    localparam int LOS_MASK_BIT = 6;
    localparam int OE_BIT = 1;
    localparam int DRV_LSB = 6;
    localparam int DIS_LSB = 4;
    localparam int POL_LSB = 6;
    localparam int INT_XTAL_BIT = 4;
    localparam int INT_W = 5;
    // codes
    localparam logic [2:0] FMT_LVCMOS = 3'h6;
    localparam logic [1:0] DIS_HIGH = 2'h1;
    // values after reset
    localparam logic RST_KILL = 1'b1;
    localparam logic RST_LOS_MASK = 1'b0;
    localparam logic [3:0] RST_UNLOCK_MASK = 4'hF;
    localparam logic RST_MODE = 1'b1;
    localparam logic RST_OE = 1'b1;
    localparam logic [7:0] RST_CFG = 8'hC6;
    localparam logic [1:0] RST_POL = 2'h0;
    localparam logic [INT_W-1:0] RST_INT_MASK = 5'h00;
endpackage : ckoe_pkg

// ### pkg/ckoe_out_if.sv
// interface: control bundle from the enable logic to one output driver
`timescale 1ns/1ps
interface ckoe_out_if;
    logic src;           // source clock level
    logic en;            // final enable
    logic [1:0] dis_sel; // level while disabled
    logic [1:0] pol;     // polarity field
    logic lvcmos;        // single-ended format
    modport ctl (output src, output en, output dis_sel, output pol, output lvcmos);
    modport drv (input src, input en, input dis_sel, input pol, input lvcmos);
endinterface : ckoe_out_if

// ### verilog/ckoe_sync.sv
// module: two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module ckoe_sync #(
    parameter int W = 1 // number of levels
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg; // first stage, read only by second
    // both stages reset low; alarms read as clear until sampled
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ckoe_sync

// ### verilog/ckoe_drv.sv
// module: one output driver, true and complement pins
`timescale 1ns/1ps
module ckoe_drv (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    ckoe_out_if.drv oif,
    output logic true_out,
    output logic comp_out
);
    import ckoe_pkg::*;
    wire dis_hi = (oif.dis_sel == DIS_HIGH); // static level when off
    // polarity only in single-ended mode; differential is always opposite
    wire t_lvl = oif.src ^ (oif.lvcmos & oif.pol[1]);
    wire c_lvl = oif.lvcmos ? (oif.src ^ oif.pol[0]) : ~oif.src;
    // single-ended parks both pins at the level, differential splits them
    wire c_dis = oif.lvcmos ? dis_hi : ~dis_hi;
    // pins registered so they are glitch-free
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            true_out <= 1'b0;
            comp_out <= 1'b0;
        end else begin
            true_out <= oif.en ? t_lvl : dis_hi;
            comp_out <= oif.en ? c_lvl : c_dis;
        end
    end
    AST_DIS_LEVEL: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !oif.en |=> true_out == $past(dis_hi))
        else $error("disabled output not at selected level");
    AST_IN_PHASE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        oif.en && oif.lvcmos && oif.pol == 2'h0 |=> true_out == comp_out)
        else $error("single-ended pins not in phase");
    AST_COMPL: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        oif.en && oif.lvcmos && oif.pol == 2'h1 |=> true_out != comp_out)
        else $error("complement polarity not applied");
    AST_TOGGLE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        oif.en && oif.lvcmos |=> true_out == ($past(oif.src) ^ $past(oif.pol[1])))
        else $error("enabled output does not follow source");
endmodule : ckoe_drv

// ### verilog/ckoe_top.sv
// module: enable, disable level and polarity control of seven clock outputs
//
// How it works
// - outputs_off_pin high disables every driver
// - each output also disabled by its own bit
// - disabled driver holds selected static level
// - unlock keeps clocks unless standard-mode option set and loop mask bit cleared
// - crystal_loss_alarm follows crystal failure
// - crystal loss disables all outputs by default
// - single-ended mode drives clock on both pins
// - pins in phase after reset
// - polarity field sets pin polarities, single-ended
// - drive field picks impedance step per output
// - global_output_kill low disables all outputs
// - per_output_enable_bit works only with pin low
// - unlock_disable_mask per loop, default keeps enabled
// - disabled_level_select field sets disabled level
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module ckoe_top #(
    // loop feeding each output, two bits per output
    parameter logic [13:0] OUT_LOOP_MAP = 14'h0000
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [7:0] rd_data_out,
    input wire logic outputs_off_pin_in,
    input wire logic crystal_fail_in,
    input wire logic [ckoe_pkg::NUM_LOOP-1:0] pll_unlock_in,
    input wire logic [ckoe_pkg::NUM_OUT-1:0] src_clk_in,
    output logic [ckoe_pkg::NUM_OUT-1:0] true_pin_out,
    output logic [ckoe_pkg::NUM_OUT-1:0] complement_pin_out,
    output logic [2*ckoe_pkg::NUM_OUT-1:0] drive_select_out,
    output logic crystal_loss_alarm_out,
    output logic irq_out
);
    import ckoe_pkg::*;

    // synchronised inputs
    logic [SYNC_W-1:0] sync_w;   // {unlock[3:0], crystal, pin}
    logic off_s;                 // pin, clock domain
    logic xtal_s;                // crystal failure, clock domain
    logic [NUM_LOOP-1:0] unl_s;  // unlock per loop

    // software registers
    logic kill_reg;                    // 1 lets per-output bits rule
    logic los_mask_reg;                // 1 keeps outputs on crystal loss
    logic [NUM_LOOP-1:0] umask_reg;    // 1 keeps outputs on unlock
    logic mode_reg;                    // standard input mode
    logic [NUM_OUT-1:0] oe_reg;        // per-output enables
    logic [7:0] cfg_reg [NUM_OUT];     // drive, level, sync, format
    logic [1:0] pol_reg [NUM_OUT];     // polarity fields
    logic [INT_W-1:0] imask_reg;       // interrupt mask

    // status and outputs
    logic [NUM_OUT-1:0] en_reg;        // final enables
    logic [NUM_OUT-1:0] en_next;       // next final enables
    logic [INT_W-1:0] stat_reg;        // sticky events
    logic [INT_W-1:0] stat_next;       // next sticky events
    logic [INT_W-1:0] ev_prev_reg;     // event levels one cycle ago
    logic [7:0] rd_next;               // read mux result

    // decode
    logic [NUM_OUT-1:0] hit_oe;        // per-output enable byte
    logic [NUM_OUT-1:0] hit_cfg;       // per-output config byte
    logic [NUM_OUT-1:0] hit_pol;       // per-output polarity byte
    wire hit_kill = (addr_in == ADDR_KILL);
    wire hit_los = (addr_in == ADDR_LOS_MASK);
    wire hit_umask = (addr_in == ADDR_UNLOCK_MASK);
    wire hit_mode = (addr_in == ADDR_MODE);
    wire hit_stat = (addr_in == ADDR_INT_STAT);
    wire hit_imask = (addr_in == ADDR_INT_MASK);
    wire hit_en = (addr_in == ADDR_EN_STAT);

    // decoded write strobes
    wire wr_kill = wr_strobe_in & hit_kill;
    wire wr_los = wr_strobe_in & hit_los;
    wire wr_umask = wr_strobe_in & hit_umask;
    wire wr_mode = wr_strobe_in & hit_mode;
    wire wr_stat = wr_strobe_in & hit_stat;
    wire wr_imask = wr_strobe_in & hit_imask;

    // loop lookup, used for mask and level alike
    function automatic logic [1:0] loop_of(input int idx);
        loop_of = OUT_LOOP_MAP[2*idx +: 2];
    endfunction : loop_of

    // pin and alarms cross into the clock domain first
    ckoe_sync #(
        .W(SYNC_W)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .async_in({pll_unlock_in, crystal_fail_in, outputs_off_pin_in}),
        .sync_out(sync_w)
    );

    assign off_s = sync_w[0];
    assign xtal_s = sync_w[1];
    assign unl_s = sync_w[5:2];

    // crystal disable source, maskable
    wire xtal_kill = xtal_s & ~los_mask_reg;

    // common gate of all outputs
    wire all_ok = ~off_s & kill_reg & ~xtal_kill;

    // per-output enable, drivers and decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            ckoe_out_if oif ();
            // unlock only disables in standard mode with mask cleared
            wire unl_kill = mode_reg & unl_s[loop_of(gi)]
                & ~umask_reg[loop_of(gi)];
            // pin low is needed before the own bit can enable
            assign en_next[gi] = all_ok & oe_reg[gi] & ~unl_kill;
            assign hit_oe[gi] = (addr_in == ADDR_OE[gi]);
            assign hit_cfg[gi] = (addr_in == ADDR_CFG[gi]);
            assign hit_pol[gi] = (addr_in == ADDR_POL[gi]);
            assign oif.src = src_clk_in[gi];
            assign oif.en = en_reg[gi];
            assign oif.dis_sel = cfg_reg[gi][DIS_LSB +: 2];
            assign oif.pol = pol_reg[gi];
            assign oif.lvcmos = (cfg_reg[gi][2:0] == FMT_LVCMOS);
            // drive code goes to the pad impedance selector
            assign drive_select_out[2*gi +: 2] = cfg_reg[gi][DRV_LSB +: 2];
            ckoe_drv u_drv (
                .core_clk_in(core_clk_in),
                .rstn_in(rstn_in),
                .oif(oif),
                .true_out(true_pin_out[gi]),
                .comp_out(complement_pin_out[gi])
            );
            // per-output registers
            always_ff @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    oe_reg[gi] <= RST_OE;
                    cfg_reg[gi] <= RST_CFG;
                    pol_reg[gi] <= RST_POL;
                end else if (wr_strobe_in) begin
                    if (hit_oe[gi]) begin
                        oe_reg[gi] <= wr_data_in[OE_BIT];
                    end
                    if (hit_cfg[gi]) begin
                        cfg_reg[gi] <= wr_data_in;
                    end
                    if (hit_pol[gi]) begin
                        pol_reg[gi] <= wr_data_in[POL_LSB +: 2];
                    end
                end
            end
        end
    endgenerate

    // global control registers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            kill_reg <= RST_KILL;
            los_mask_reg <= RST_LOS_MASK;
            umask_reg <= RST_UNLOCK_MASK;
            mode_reg <= RST_MODE;
            imask_reg <= RST_INT_MASK;
        end else begin
            if (wr_kill) begin
                kill_reg <= wr_data_in[KILL_BIT];
            end
            if (wr_los) begin
                los_mask_reg <= wr_data_in[LOS_MASK_BIT];
            end
            if (wr_umask) begin
                umask_reg <= wr_data_in[NUM_LOOP-1:0];
            end
            if (wr_mode) begin
                mode_reg <= wr_data_in[0];
            end
            if (wr_imask) begin
                imask_reg <= wr_data_in[INT_W-1:0];
            end
        end
    end

    // final enables, one cycle after the synchronisers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            en_reg <= '0;
        end else begin
            en_reg <= en_next;
        end
    end

    // alarm output mirrors the synchronised failure
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            crystal_loss_alarm_out <= 1'b0;
        end else begin
            crystal_loss_alarm_out <= xtal_s;
        end
    end

    // rising edges of alarms become sticky events
    wire [INT_W-1:0] ev_lvl = {xtal_s, unl_s};
    wire [INT_W-1:0] ev_rise = ev_lvl & ~ev_prev_reg;
    // write one clears, but a new edge in the same cycle wins
    assign stat_next = (stat_reg & ~(wr_stat ? wr_data_in[INT_W-1:0] : '0)) | ev_rise;

    // event bookkeeping; irq sees a mask written in the same cycle so it never lags
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ev_prev_reg <= '0;
            stat_reg <= '0;
            irq_out <= 1'b0;
        end else begin
            ev_prev_reg <= ev_lvl;
            stat_reg <= stat_next;
            irq_out <= |(stat_next & (wr_imask ? wr_data_in[INT_W-1:0] : imask_reg));
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_next = 8'h00;
        if (hit_kill) begin
            rd_next[KILL_BIT] = kill_reg;
        end
        if (hit_los) begin
            rd_next[LOS_MASK_BIT] = los_mask_reg;
        end
        if (hit_umask) begin
            rd_next[NUM_LOOP-1:0] = umask_reg;
        end
        if (hit_mode) begin
            rd_next[0] = mode_reg;
        end
        if (hit_stat) begin
            rd_next[INT_W-1:0] = stat_reg;
        end
        if (hit_imask) begin
            rd_next[INT_W-1:0] = imask_reg;
        end
        if (hit_en) begin
            rd_next[NUM_OUT-1:0] = en_reg;
        end
        for (int i = 0; i < NUM_OUT; i++) begin
            if (hit_oe[i]) begin
                rd_next[OE_BIT] = oe_reg[i];
            end
            if (hit_cfg[i]) begin
                rd_next = cfg_reg[i];
            end
            if (hit_pol[i]) begin
                rd_next[POL_LSB +: 2] = pol_reg[i];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= rd_strobe_in ? rd_next : 8'h00;
        end
    end

    // checks on the enable combination, alarm, interrupt and read data
    AST_PIN_OFF: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        off_s |=> en_reg == '0)
        else $error("pin high but an output is enabled");
    AST_PIN_SYNC: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        outputs_off_pin_in [*3] |=> en_reg == '0)
        else $error("pin not honoured after two sync stages");
    AST_OWN_BIT: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !oe_reg[0] |=> !en_reg[0])
        else $error("output 0 enabled with its bit cleared");
    AST_OWN_ON: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !off_s && kill_reg && oe_reg[3] && !xtal_s && umask_reg == 4'hF |=> en_reg[3])
        else $error("output 3 not enabled with pin low and bit set");
    AST_KILL: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !kill_reg |=> en_reg == '0)
        else $error("global kill low but an output is enabled");
    AST_XTAL_OFF: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        xtal_s && !los_mask_reg |=> en_reg == '0)
        else $error("crystal loss did not disable outputs");
    AST_ALARM: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(xtal_s) |=> crystal_loss_alarm_out ##1 stat_reg[INT_XTAL_BIT])
        else $error("crystal alarm or event missing");
    AST_UNLOCK_DIS: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        mode_reg && unl_s[loop_of(0)] && !umask_reg[loop_of(0)] |=> !en_reg[0])
        else $error("unlock did not disable output 0");
    AST_UNLOCK_KEEP: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        unl_s != 4'h0 && !off_s && kill_reg && oe_reg[0] && !xtal_s
        && umask_reg == 4'hF |=> en_reg[0])
        else $error("unlock disabled output 0 while masked");
    AST_IRQ: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (stat_reg & imask_reg) != '0 |-> irq_out)
        else $error("unmasked event without interrupt");
    AST_RD: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        rd_strobe_in && hit_kill |=> rd_data_out == {7'h00, $past(kill_reg)})
        else $error("read data wrong for global kill");

    // main scenarios
    COV_PIN_OFF: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        en_reg != '0 ##1 off_s ##1 en_reg == '0);
    COV_XTAL_IRQ: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(xtal_s) ##[1:3] irq_out);
    COV_UNLOCK: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        mode_reg && !umask_reg[0] && unl_s[0] ##1 en_reg == '0);
endmodule : ckoe_top

// ### verification/ckoe_rx_model.sv
// model: downstream clock receivers watching the true and complement pins
`timescale 1ns/1ps
module ckoe_rx_model (
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic [6:0] true_in,
    input wire logic [6:0] comp_in,
    output logic [6:0] tog_out,
    output logic [6:0] same_out,
    output logic [6:0] opp_out,
    output logic [6:0] hi_out
);
    logic [6:0] prev_reg; // last true level seen
    // one watch window per clear pulse; receivers only listen, never drive
    always_ff @(posedge clk_in) begin
        prev_reg <= true_in;
        hi_out <= true_in;
        if (clr_in) begin
            tog_out <= '0;
            same_out <= '1;
            opp_out <= '1;
        end else begin
            tog_out <= tog_out | (true_in ^ prev_reg);
            same_out <= same_out & ~(true_in ^ comp_in);
            opp_out <= opp_out & (true_in ^ comp_in);
        end
    end
endmodule : ckoe_rx_model

// ### verification/ckoe_tb_top.sv
// testbench: registers, enables, polarity and alarms of the clock output control
`timescale 1ns/1ps
module ckoe_tb_top;
    import ckoe_pkg::*;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_strobe_in = 1'b0;
    logic rd_strobe_in = 1'b0;
    logic off_pin = 1'b0; // outputs_off_pin level
    logic xfail = 1'b0; // crystal failure
    logic [3:0] unlock = 4'h0; // per loop unlock
    logic [6:0] src = 7'h00; // source clocks
    logic clr = 1'b0; // receiver window clear
    logic [7:0] rd_data_out;
    logic [6:0] tpin, cpin, tog, same, opp, hi;
    logic [13:0] drv;
    logic alarm, irq;
    int n_fail = 0;
    int tests_run = 0;
    // reset table: address and expected value
    logic [15:0] reg_addr [8] = '{ADDR_KILL, ADDR_LOS_MASK, ADDR_UNLOCK_MASK, ADDR_MODE,
        ADDR_OE[0], ADDR_POL[0], ADDR_INT_MASK, 16'h0100};
    logic [7:0] reg_rst [8] = '{{7'h00, RST_KILL}, {1'b0, RST_LOS_MASK, 6'h00},
        {4'h0, RST_UNLOCK_MASK}, {7'h00, RST_MODE}, {6'h00, RST_OE, 1'b0},
        {RST_POL, 6'h00}, {3'h0, RST_INT_MASK}, 8'h00};

    // 40 MHz clock; sources toggle every cycle
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) src <= ~src;

    ckoe_top ckoe_top_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
        .rd_data_out(rd_data_out), .outputs_off_pin_in(off_pin), .crystal_fail_in(xfail),
        .pll_unlock_in(unlock), .src_clk_in(src), .true_pin_out(tpin),
        .complement_pin_out(cpin), .drive_select_out(drv),
        .crystal_loss_alarm_out(alarm), .irq_out(irq));
    ckoe_rx_model ckoe_rx_model_inst (.clk_in(core_clk_in), .clr_in(clr), .true_in(tpin),
        .comp_in(cpin), .tog_out(tog), .same_out(same), .opp_out(opp), .hi_out(hi));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // write cycle, entered just after an edge, leaves one idle cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_strobe_in <= 1'b1;
        @(posedge core_clk_in);
        wr_strobe_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : wr

    // read cycle; data stand only in the cycle after the strobe
    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string what);
        addr_in <= a;
        rd_strobe_in <= 1'b1;
        @(posedge core_clk_in);
        rd_strobe_in <= 1'b0;
        #1;
        check(what, {8'h00, rd_data_out}, {8'h00, e});
        @(posedge core_clk_in);
    endtask : rdc

    // let the enable path settle, then watch the pins for eight cycles
    task automatic look(input logic [6:0] t, input logic [6:0] s, input logic [6:0] h,
        input string what);
        repeat (6) @(posedge core_clk_in);
        clr <= 1'b1;
        @(posedge core_clk_in);
        clr <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        #1;
        check({what, " toggling"}, {9'h000, tog}, {9'h000, t});
        check({what, " in phase"}, {9'h000, same}, {9'h000, s});
        check({what, " level"}, {9'h000, hi & ~tog}, {9'h000, h & ~t});
        @(posedge core_clk_in);
        $display("test %s done", what);
    endtask : look

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk_in);
        n_fail++;
        results();
    end

    initial begin
        repeat (5) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        // reset values, unmapped place ignores writes
        wr(16'h0100, 8'hFF);
        for (int i = 0; i < 8; i++) rdc(reg_addr[i], reg_rst[i], "reset value");
        for (int i = 0; i < NUM_OUT; i++) rdc(ADDR_CFG[i], RST_CFG, "cfg reset");
        check("drive reset", {2'h0, drv}, {2'h0, {NUM_OUT{RST_CFG[7:6]}}});
        look(7'h7F, 7'h7F, 7'h00, "default");
        // all four polarity codes on outputs 0 to 3
        // output 6 differential: its polarity field must be ignored, pins stay opposite
        wr(ADDR_CFG[6], 8'hC1);
        wr(ADDR_POL[6], 8'hC0);
        for (int i = 0; i < 4; i++) wr(ADDR_POL[i], {2'(i), 6'h00});
        rdc(ADDR_POL[3], 8'hC0, "polarity readback");
        look(7'h7F, 7'h39, 7'h00, "polarity");
        check("opposite pins", {9'h000, opp}, 16'h0046);
        for (int i = 0; i < 4; i++) wr(ADDR_POL[i], 8'h00);
        wr(ADDR_POL[6], 8'h00);
        wr(ADDR_CFG[6], RST_CFG);
        // impedance codes 1 to 3, ending on the lowest impedance; format and level kept
        for (int k = 1; k < 4; k++) begin
            wr(ADDR_CFG[4], {2'(k), 6'h06});
            check("drive code", {14'h0000, drv[9:8]}, 16'(k));
        end
        // output 5 disabled alone, parked high
        wr(ADDR_CFG[5], 8'hD6);
        wr(ADDR_OE[5], 8'h00);
        look(7'h5F, 7'h7F, 7'h20, "single disable");
        rdc(ADDR_EN_STAT, 8'h5F, "enable status");
        wr(ADDR_OE[5], 8'h02);
        wr(ADDR_KILL, 8'h00);
        look(7'h00, 7'h7F, 7'h20, "kill");
        rdc(ADDR_EN_STAT, 8'h00, "kill status");
        wr(ADDR_KILL, 8'h01);
        off_pin <= 1'b1;
        look(7'h00, 7'h7F, 7'h20, "pin high");
        off_pin <= 1'b0;
        look(7'h7F, 7'h7F, 7'h00, "pin low");
        // crystal loss: alarm through the synchroniser, outputs parked
        xfail <= 1'b1;
        @(posedge core_clk_in);
        #1;
        check("alarm early", {15'h0000, alarm}, 16'h0000);
        repeat (4) @(posedge core_clk_in);
        #1;
        check("alarm", {15'h0000, alarm}, 16'h0001);
        @(posedge core_clk_in);
        look(7'h00, 7'h7F, 7'h20, "crystal loss");
        rdc(ADDR_INT_STAT, 8'h10, "crystal event");
        check("irq masked", {15'h0000, irq}, 16'h0000);
        wr(ADDR_INT_MASK, 8'h10);
        @(negedge core_clk_in);
        check("irq raised", {15'h0000, irq}, 16'h0001);
        @(posedge core_clk_in);
        wr(ADDR_INT_STAT, 8'h10);
        @(negedge core_clk_in);
        check("irq cleared", {15'h0000, irq}, 16'h0000);
        @(posedge core_clk_in);
        wr(ADDR_INT_MASK, 8'h00);
        wr(ADDR_LOS_MASK, 8'h40);
        look(7'h7F, 7'h7F, 7'h00, "crystal masked");
        wr(ADDR_LOS_MASK, 8'h00);
        xfail <= 1'b0;
        // unlock of loop 0, which feeds every output
        unlock <= 4'h1;
        look(7'h7F, 7'h7F, 7'h00, "unlock kept");
        rdc(ADDR_INT_STAT, 8'h01, "unlock event");
        wr(ADDR_UNLOCK_MASK, 8'h0E);
        look(7'h00, 7'h7F, 7'h20, "unlock disables");
        wr(ADDR_MODE, 8'h00);
        look(7'h7F, 7'h7F, 7'h00, "other input mode");
        results();
    end
endmodule : ckoe_tb_top
